// ### design/spi_master_slave_port.sv
`timescale 1ns/1ns
`include "spi_cfg.svh"

// How it works
// - Interrupt follows TX or RX flag per mode
// - RX overflow flag set, cleared by RX read
// - RX irq is full or overflow, read clears
// - RX full while unread byte waits
// - TX underflow flag cleared by TX write
// - TX irq: while enabled, not full or underflow
// - TX full from write until sent
// - Byte registers, eight bits per transfer
// - Eight-bit divider resets to 0x1B
// - Continuous master keeps chip select low
// - Single transfers separated by stall period
// - Loopback routes our outgoing bit back into the receiver
// - Open drain MISO when bit set
// - Master chip select suppressed by bit 9
// - Overflow overwrites or discards new byte
// - Underflow sends zero or previous byte
// - Start on TX write or RX read
// - LSB or MSB first selection
// - Serial clock idle level from polarity
// - Clock pulse at start or end
// - Master or slave role select
// - Port enabled only while bit 0 set
module spi_master_slave_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire spi_pkg::pins_in_t pins_in,
    output spi_pkg::pins_out_t pins_out,
    // Interrupt
    output logic irq
);

    // ----------------
    // Declarations
    // ----------------
    logic [15:0] control; // Control register
    logic [7:0] divider; // Clock divider register
    logic [7:0] tx_data; // Last byte written by software
    logic [7:0] last_tx; // Previous byte really sent
    logic [7:0] rx_data; // Received byte held for software
    logic tx_full; // Data not yet completely sent
    logic tx_fresh; // Written but not yet loaded
    logic tx_under; // Underflow seen
    logic rx_full; // Unread byte present
    logic rx_over; // Overflow seen
    logic go; // Master start request from RX read
    logic [7:0] tx_sr; // Transmit shifter
    logic [7:0] rx_sr; // Receive shifter
    logic [3:0] bitcnt; // Bits sampled in this byte
    logic [3:0] hcnt; // Master half-bit index
    spi_pkg::master_state_t state; // Master sequencer
    spi_pkg::master_state_t next_state;
    spi_pkg::pins_in_t pins_s; // Synchronised pins
    logic sclk_prev; // Previous synchronised sclk
    logic cs_prev; // Previous synchronised chip select
    logic tick; // Half-bit tick
    logic [7:0] next_rx; // Receive shifter after this sample
    logic [7:0] load_val; // Byte loaded into the shifter
    logic [7:0] status; // Status view
    logic acc; // APB access phase
    logic hit; // Address maps to a register
    logic wr_tx, rd_rx, wr_div, wr_con;
    logic en, master, cpha, cpol, lsb;
    logic tx_irq, rx_irq;
    logic m_act, m_start, m_mid, m_end, m_done, m_cont;
    logic s_act, s_sel, cs_fall, sclk_chg, lead, trail;
    logic load_ev, sample_ev, shift_ev, done_ev;
    logic tx_bit, rx_bit;

    // ----------------
    // Control fields
    // ----------------
    assign en = control[`CON_ENABLE];
    assign master = en && control[`CON_MASTER];
    assign cpha = control[`CON_PHASE];
    assign cpol = control[`CON_POLARITY];
    assign lsb = control[`CON_LSB_FIRST];

    // ----------------
    // APB decode
    // ----------------
    // Zero wait states: every access completes in its first cycle
    assign pready = 1'b1;
    assign acc = psel && penable;
    assign hit = (paddr == `ADDR_STATUS) || (paddr == `ADDR_RX_DATA) ||
                 (paddr == `ADDR_TX_DATA) || (paddr == `ADDR_DIVIDER) ||
                 (paddr == `ADDR_CONTROL);
    assign pslverr = acc && !hit;
    assign wr_tx = acc && pwrite && (paddr == `ADDR_TX_DATA);
    assign rd_rx = acc && !pwrite && (paddr == `ADDR_RX_DATA);
    assign wr_div = acc && pwrite && (paddr == `ADDR_DIVIDER);
    assign wr_con = acc && pwrite && (paddr == `ADDR_CONTROL);

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `ADDR_STATUS: prdata <= {24'h00_0000, status};
                `ADDR_RX_DATA: prdata <= {24'h00_0000, rx_data};
                `ADDR_DIVIDER: prdata <= {24'h00_0000, divider};
                `ADDR_CONTROL: prdata <= {16'h0000, control};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `RST_CONTROL;
            divider <= `RST_DIVIDER;
        end else begin
            if (wr_con) begin
                control <= pwdata[15:0] & `CONTROL_MASK;
            end
            if (wr_div) begin
                divider <= pwdata[7:0];
            end
        end
    end

    // ----------------
    // Status and interrupt
    // ----------------
    assign rx_irq = rx_full || rx_over;
    // Disabling the port after the last byte drops the TX request
    assign tx_irq = en && (!tx_full || tx_under);
    assign status = {2'b00, rx_over, rx_irq, rx_full,
                     tx_under, tx_irq, tx_full};
    // Only one source reaches the pin, as picked by the start mode
    assign irq = control[`CON_TX_START] ? tx_irq : rx_irq;

    // ----------------
    // Pin synchronisers and slave edge detect
    // ----------------
    pin_sync #(
        .W(4)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_in),
        .sync_out(pins_s)
    );

    // Previous values of the synchronised clock and select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            sclk_prev <= pins_s.sclk;
            cs_prev <= pins_s.cs_n;
        end
    end

    assign s_act = en && !master;
    assign s_sel = s_act && !pins_s.cs_n;
    assign cs_fall = s_act && cs_prev && !pins_s.cs_n;
    assign sclk_chg = s_sel && (pins_s.sclk != sclk_prev);
    // Leading edge leaves the idle level, trailing edge returns to it
    assign lead = sclk_chg && (pins_s.sclk != cpol);
    assign trail = sclk_chg && (pins_s.sclk == cpol);

    // ----------------
    // Master sequencer
    // ----------------
    sclk_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(state != spi_pkg::ST_IDLE),
        .div(divider),
        .tick(tick)
    );

    assign m_act = master;
    assign m_start = m_act && (state == spi_pkg::ST_IDLE) &&
                     (control[`CON_TX_START] ? tx_fresh : go);
    assign m_mid = (state == spi_pkg::ST_RUN) && tick && !hcnt[0];
    assign m_end = (state == spi_pkg::ST_RUN) && tick && hcnt[0];
    assign m_done = m_end && (hcnt == `LAST_HALF);
    // Fresh data in continuous mode goes out with no gap
    assign m_cont = m_done && control[`CON_CONTINUOUS] && tx_fresh;

    // Next state of the sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            spi_pkg::ST_IDLE: begin
                if (m_start) begin
                    next_state = spi_pkg::ST_RUN;
                end
            end
            spi_pkg::ST_RUN: begin
                if (m_done && !m_cont) begin
                    next_state = spi_pkg::ST_GAP;
                end
            end
            spi_pkg::ST_GAP: begin
                // Stall of one half bit with chip select released
                if (tick) begin
                    next_state = spi_pkg::ST_IDLE;
                end
            end
            default: next_state = spi_pkg::ST_IDLE;
        endcase
        if (!m_act) begin
            next_state = spi_pkg::ST_IDLE;
        end
    end

    // State and half-bit index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= spi_pkg::ST_IDLE;
            hcnt <= 4'h0;
        end else begin
            state <= next_state;
            if (next_state != spi_pkg::ST_RUN || m_start) begin
                hcnt <= 4'h0;
            end else if (tick) begin
                hcnt <= hcnt + 4'h1;
            end
        end
    end

    // Read-started transfer request, set wins over its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go <= 1'b0;
        end else if (!m_act) begin
            go <= 1'b0;
        end else if (rd_rx) begin
            go <= 1'b1;
        end else if (m_start) begin
            go <= 1'b0;
        end
    end

    // ----------------
    // Shift events shared by both roles
    // ----------------
    // Master samples at mid bit and shifts at bit end in both phases;
    // the phase bit only moves where the clock edges fall
    assign load_ev = m_start || m_cont || cs_fall || (done_ev && s_sel);
    assign sample_ev = m_mid || (s_sel && (cpha ? trail : lead));
    // Slave skips the shift edge right after a load, so bit 0 stays
    assign shift_ev = (m_end && !m_done) ||
                      ((cpha ? lead : trail) && (bitcnt != 4'h0));
    assign done_ev = sample_ev && (bitcnt == `BITS_PER_BYTE - 4'h1);

    assign tx_bit = lsb ? tx_sr[0] : tx_sr[7];
    // Loopback feeds our own outgoing bit back into the receiver
    assign rx_bit = control[`CON_LOOPBACK] ? tx_bit :
                    (master ? pins_s.miso : pins_s.mosi);
    assign next_rx = lsb ? {rx_bit, rx_sr[7:1]} :
                           {rx_sr[6:0], rx_bit};
    // No fresh data: zero or repeat the last byte actually sent
    assign load_val = tx_fresh ? tx_data :
                      (control[`CON_UNDER_ZERO] ? 8'h00 : last_tx);

    // Shifters and bit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sr <= 8'h00;
            rx_sr <= 8'h00;
            bitcnt <= 4'h0;
        end else begin
            if (load_ev) begin
                tx_sr <= load_val;
            end else if (shift_ev) begin
                tx_sr <= lsb ? {1'b0, tx_sr[7:1]} : {tx_sr[6:0], 1'b0};
            end
            if (sample_ev) begin
                rx_sr <= next_rx;
            end
            // Select lost mid byte, or a new byte begins
            if (load_ev || done_ev || (s_act && pins_s.cs_n)) begin
                bitcnt <= 4'h0;
            end else if (sample_ev) begin
                bitcnt <= bitcnt + 4'h1;
            end
        end
    end

    // ----------------
    // Transmit holding register and flags
    // ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= `RST_BYTE;
            last_tx <= `RST_BYTE;
        end else begin
            if (wr_tx) begin
                tx_data <= pwdata[7:0];
            end
            if (load_ev && tx_fresh) begin
                last_tx <= tx_data;
            end
        end
    end

    // Occupied flag: set by write, dropped when the byte is out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full <= 1'b0;
            tx_fresh <= 1'b0;
        end else begin
            if (wr_tx) begin
                tx_full <= 1'b1;
            end else if (done_ev && !tx_fresh) begin
                tx_full <= 1'b0;
            end
            if (wr_tx) begin
                tx_fresh <= 1'b1;
            end else if (load_ev) begin
                tx_fresh <= 1'b0;
            end
        end
    end

    // Underflow: a byte left with nothing new; the set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_under <= 1'b0;
        end else if (load_ev && !tx_fresh) begin
            tx_under <= 1'b1;
        end else if (wr_tx) begin
            tx_under <= 1'b0;
        end
    end

    // ----------------
    // Receive register and flags
    // ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= `RST_BYTE;
        end else if (done_ev && (!rx_full || control[`CON_OVERWRITE])) begin
            rx_data <= next_rx;
        end
    end

    // New byte beats a read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_full <= 1'b0;
            rx_over <= 1'b0;
        end else begin
            if (done_ev) begin
                rx_full <= 1'b1;
            end else if (rd_rx) begin
                rx_full <= 1'b0;
            end
            if (done_ev && rx_full) begin
                rx_over <= 1'b1;
            end else if (rd_rx) begin
                rx_over <= 1'b0;
            end
        end
    end

    // ----------------
    // Pin drivers, registered
    // ----------------
    // Outputs trail the sequencer by one clock, which is uniform for
    // clock and data so their relation on the wire is unchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_out <= '0;
        end else begin
            pins_out.sclk <= cpol ^ ((state == spi_pkg::ST_RUN) &&
                             (cpha ? !hcnt[0] : hcnt[0]));
            pins_out.sclk_oe <= m_act;
            pins_out.mosi <= tx_bit;
            pins_out.mosi_oe <= m_act;
            // Select held low across back-to-back continuous bytes
            pins_out.cs_n <= (state != spi_pkg::ST_RUN);
            pins_out.cs_n_oe <= m_act && !control[`CON_CS_OFF];
            // Open drain: only ever pull low
            pins_out.miso <= control[`CON_OPEN_DRAIN] ? 1'b0 : tx_bit;
            pins_out.miso_oe <= s_sel && (!control[`CON_OPEN_DRAIN] ||
                                !tx_bit);
        end
    end

endmodule // spi_master_slave_port

// ### include/spi_cfg.svh
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH

// ----------------
// Register byte addresses
// ----------------
`define ADDR_STATUS 32'hffff_0a00
`define ADDR_RX_DATA 32'hffff_0a04
`define ADDR_TX_DATA 32'hffff_0a08
`define ADDR_DIVIDER 32'hffff_0a0c
`define ADDR_CONTROL 32'hffff_0a10

// ----------------
// Reset values
// ----------------
`define RST_DIVIDER 8'h1b
`define RST_CONTROL 16'h0000
`define RST_BYTE 8'h00
// Writable control bits; 15:13 and 4 read as zero
`define CONTROL_MASK 16'h1fef

// ----------------
// Control bit positions
// ----------------
`define CON_ENABLE 0
`define CON_MASTER 1
`define CON_PHASE 2
`define CON_POLARITY 3
`define CON_LSB_FIRST 5
`define CON_TX_START 6
`define CON_UNDER_ZERO 7
`define CON_OVERWRITE 8
`define CON_CS_OFF 9
`define CON_OPEN_DRAIN 10
`define CON_LOOPBACK 11
`define CON_CONTINUOUS 12

// ----------------
// Status bit positions
// ----------------
`define STA_TX_FULL 0
`define STA_TX_IRQ 1
`define STA_TX_UNDER 2
`define STA_RX_FULL 3
`define STA_RX_IRQ 4
`define STA_RX_OVER 5

// ----------------
// Transfer shape
// ----------------
`define BITS_PER_BYTE 4'h8
`define LAST_HALF 4'hf

`endif

// ### include/spi_pkg.sv
package spi_pkg;

    // Serial pins as seen from outside the core clock domain
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic cs_n;
    } pins_in_t;

    // Driven pins, each with its output enable
    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
        logic cs_n;
        logic cs_n_oe;
    } pins_out_t;

    // Master sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_GAP = 3'b100
    } master_state_t;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/1ns

// Two-stage synchroniser for asynchronous pin inputs
module pin_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous in, synchronised out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [W-1:0] meta;

    // ----------------------------------------------------------------
    // Two stages per bit; reset state is all ones (idle pins)
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule // pin_sync

// ### design/sclk_divider.sv
`timescale 1ns/1ns

// Half-bit tick generator: one tick every (div + 1) clocks
module sclk_divider (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [7:0] div,
    // One-cycle pulse at the end of each half bit
    output logic tick
);

    // Cycles elapsed in the current half bit
    logic [7:0] count;

    assign tick = run && (count == div);

    // ----------------------------------------------------------------
    // Counter restarts whenever the sequencer is not running
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 8'h00;
        end else if (!run || tick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end

endmodule // sclk_divider

// ### bench/spi_port_monitor.sv
`timescale 1ns/1ns
`include "spi_cfg.svh"
// Watches bus and pins; shadows the set-up words it needs
module spi_port_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial pins and interrupt
    input wire spi_pkg::pins_in_t pins_in,
    input wire spi_pkg::pins_out_t pins_out,
    input wire logic irq
);
    logic [15:0] ctl; // Control shadow
    logic [7:0] dv; // Divider shadow
    logic [8:0] gap; // Clocks since the serial clock moved
    logic inf; // Clock already moved in this frame
    wire acc = psel && penable;
    wire rd_sta = acc && !pwrite && paddr == `ADDR_STATUS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadows follow completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 16'h0000;
            dv <= 8'h1b;
        end else if (acc && pwrite) begin
            if (paddr == `ADDR_CONTROL) ctl <= pwdata[15:0];
            if (paddr == `ADDR_DIVIDER) dv <= pwdata[7:0];
        end
    end
    // Half-bit timer; a counter, since the span can reach 256 clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 9'h000;
            inf <= 1'b0;
        end else begin
            gap <= $changed(pins_out.sclk) ? 9'h000 : gap + 9'h001;
            inf <= !pins_out.cs_n && (inf || $changed(pins_out.sclk));
        end
    end
    property p_bus_answer;
        acc |-> pready && (pslverr == !(paddr inside {`ADDR_STATUS,
            `ADDR_RX_DATA, `ADDR_TX_DATA, `ADDR_DIVIDER, `ADDR_CONTROL}));
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer wrong");
    property p_irq_pick;
        psel && !penable && !pwrite && paddr == `ADDR_STATUS
            |=> prdata[ctl[6] ? 1 : 4] == $past(irq);
    endproperty
    a_irq_pick: assert property (p_irq_pick)
        else $error("irq source wrong");
    property p_rx_irq;
        rd_sta |-> prdata[4] == (prdata[3] | prdata[5]);
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("rx irq flag wrong");
    property p_tx_irq;
        rd_sta && ctl[0] |-> prdata[1] == (!prdata[0] | prdata[2]);
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("tx irq flag wrong");
    property p_stall;
        $rose(pins_out.cs_n) && ctl[1:0] == 2'b11 && !ctl[12]
            |=> pins_out.cs_n;
    endproperty
    a_stall: assert property (p_stall)
        else $error("no stall after byte");
    property p_open_drain;
        ctl[10] && $past(ctl[10], 2) && pins_out.miso_oe |-> !pins_out.miso;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("miso driven high");
    property p_cs_off;
        ctl[9] && ctl[1] && $past(ctl[9], 2) && $past(ctl[1], 2)
            |-> !(pins_out.cs_n_oe && !pins_out.cs_n);
    endproperty
    a_cs_off: assert property (p_cs_off)
        else $error("select driven while off");
    property p_half_bit;
        inf && !pins_out.cs_n && pins_out.sclk_oe && ctl[1:0] == 2'b11
            && $changed(pins_out.sclk) |-> gap == {1'b0, dv};
    endproperty
    a_half_bit: assert property (p_half_bit)
        else $error("half bit length wrong");
    c_frame: cover property ($rose(pins_out.cs_n));
    c_irq: cover property ($rose(irq));
    c_refused: cover property (acc && pslverr);
endmodule // spi_port_monitor

bind spi_master_slave_port spi_port_monitor u_mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

// ### bench/spi_peer_model.sv
`timescale 1ns/1ns
// Far side in slave role: captures MOSI, answers with its complement
module spi_peer_model (
    // Wire levels
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    // Clock mode shared with the port
    input wire logic cpol,
    input wire logic cpha,
    // Answer, captured bits, frames seen
    output logic miso,
    output logic [7:0] sh,
    output int frames
);
    initial begin
        sh = '0;
        frames = 0;
        miso = 1'b1;
    end
    // Sample mid bit: leading edge in phase 0, trailing in phase 1
    always @(sclk) begin
        if (!cs_n && ((sclk != cpol) ^ cpha)) sh = {sh[6:0], mosi};
    end
    always @(posedge cs_n) frames++;
    // Released line goes to its pull-up level
    always @(mosi or cs_n) miso = cs_n ? 1'b1 : ~mosi;
endmodule // spi_peer_model

// ### bench/spi_master_slave_port_tb.sv
`timescale 1ns/1ns
`include "spi_cfg.svh"
module spi_master_slave_port_tb;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, e;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic pready, pslverr, irq, mmiso, ssclk = '0, smosi = '0, scs = '1;
    logic [7:0] b1, b2, mb, sb, got, psh;
    logic [15:0] cf = '0;
    int error_cnt = 0, check_count = 0, pfr, f0;
    spi_pkg::pins_in_t pins_in;
    spi_pkg::pins_out_t po;
    always #2 pclk = ~pclk;
    // Wire levels: driver wins, else far side, else pull-up
    assign pins_in.sclk = po.sclk_oe ? po.sclk : ssclk;
    assign pins_in.mosi = po.mosi_oe ? po.mosi : smosi;
    assign pins_in.cs_n = po.cs_n_oe ? po.cs_n : scs;
    assign pins_in.miso = po.miso_oe ? po.miso
        : (po.cs_n_oe && !po.cs_n ? mmiso : 1'b1);
    spi_master_slave_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins_in), .pins_out(po), .irq(irq));
    spi_peer_model peer (.sclk(pins_in.sclk), .mosi(pins_in.mosi),
        .cs_n(pins_in.cs_n), .cpol(cf[3]), .cpha(cf[2]), .miso(mmiso),
        .sh(psh), .frames(pfr));
    // Byte as the far side assembles it, first bit at the top
    function automatic logic [7:0] ord(input logic [7:0] x);
        for (int k = 0; k < 8; k++) ord[k] = cf[5] ? x[7 - k] : x[k];
    endfunction
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // Poll until a byte is in and the link has gone quiet
    task idle_wait;
        int n;
        n = 0;
        do begin
            apb(1'b0, `ADDR_STATUS, '0);
            n++;
        end while ((r[3] !== 1'b1 || r[0] !== 1'b0
            || pins_in.cs_n !== 1'b1) && n < 999);
        if (n >= 999) error_cnt++;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
    initial begin
        r = $urandom(97);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_STATUS, '0);
        chk(r, 32'h0000_0000);
        apb(1'b0, `ADDR_RX_DATA, '0);
        chk(r, 32'h0000_0000);
        apb(1'b0, `ADDR_DIVIDER, '0);
        chk(r, 32'h0000_001b);
        apb(1'b0, `ADDR_CONTROL + 32'h0000_0004, '0);
        chk(e, 1'b1);
        apb(1'b1, `ADDR_CONTROL, 32'hffff_ffff);
        apb(1'b0, `ADDR_CONTROL, '0);
        chk(r, 32'h0000_1fef);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            cf = 16'h0043 | (16'($urandom) & 16'h192c);
            cf[12] = i[0];
            b1 = 8'($urandom);
            b2 = (i == 1) ? 8'h00 : 8'($urandom);
            apb(1'b1, `ADDR_DIVIDER, 3 + $urandom % 3);
            apb(1'b1, `ADDR_CONTROL, cf);
            f0 = pfr;
            apb(1'b1, `ADDR_TX_DATA, b1);
            repeat (3) @(posedge pclk);
            apb(1'b1, `ADDR_TX_DATA, b2);
            idle_wait;
            chk(r[7:0], 8'h3a);
            chk(irq, 1'b1);
            chk(pfr - f0, cf[12] ? 1 : 2);
            chk(psh, ord(b2));
            apb(1'b0, `ADDR_RX_DATA, '0);
            chk(r[7:0], (cf[11] ? 8'h00 : 8'hff) ^ (cf[8] ? b2 : b1));
            apb(1'b0, `ADDR_STATUS, '0);
            chk(r[7:0], 8'h02);
        end
        $display("test master done");
        cf[6] = 1'b0;
        cf[7] = 1'($urandom);
        apb(1'b1, `ADDR_CONTROL, cf);
        apb(1'b0, `ADDR_RX_DATA, '0);
        idle_wait;
        chk(psh, ord(cf[7] ? 8'h00 : b2));
        chk(r[2], 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, `ADDR_CONTROL, '0);
        apb(1'b1, `ADDR_TX_DATA, b1);
        apb(1'b0, `ADDR_STATUS, '0);
        chk(r[2], 1'b0);
        f0 = pfr;
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0243);
        idle_wait;
        chk(pfr, f0);
        $display("test underflow done");
        apb(1'b0, `ADDR_RX_DATA, '0);
        apb(1'b1, `ADDR_CONTROL, 32'h0000_0041 | ($urandom & 32'h0000_0400));
        sb = 8'($urandom);
        mb = 8'($urandom);
        apb(1'b1, `ADDR_TX_DATA, sb);
        scs <= 1'b0;
        for (int k = 7; k >= 0; k--) begin
            smosi <= mb[k];
            repeat (20) @(posedge pclk);
            ssclk <= 1'b1;
            got[k] = pins_in.miso;
            repeat (20) @(posedge pclk);
            ssclk <= 1'b0;
        end
        repeat (20) @(posedge pclk);
        scs <= 1'b1;
        chk(got, sb);
        apb(1'b0, `ADDR_RX_DATA, '0);
        chk(r[7:0], mb);
        $display("test slave done");
        finish_test;
    end
endmodule // spi_master_slave_port_tb
